// ==== verilog/rrsb_defs.svh ====
// Register offsets, field positions, reset values and sizes of the rotate and subtract ALU.
`ifndef RRSB_DEFS_SVH
`define RRSB_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the Wishbone slave.
// ----------------------------------------------------------------------------
`define RRSB_OFS_WORK 8'h00
`define RRSB_OFS_FLAGS 8'h04
`define RRSB_OFS_CMD 8'h08
`define RRSB_OFS_STAT 8'h0C
`define RRSB_OFS_MEM 8'h40

// ----------------------------------------------------------------------------
// Data memory size, one byte per aligned word from the memory offset upward.
// ----------------------------------------------------------------------------
`define RRSB_MEM_DEPTH 16
`define RRSB_MEM_AW 4

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define RRSB_FLAG_C 0
`define RRSB_FLAG_NIB 1
`define RRSB_FLAG_Z 2
`define RRSB_FLAG_RANGE 3
`define RRSB_FLAG_SCHAIN 4
`define RRSB_FLAG_CNIL 5
`define RRSB_FLAG_W 6
`define RRSB_CMD_OP_LSB 0
`define RRSB_CMD_OP_W 3
`define RRSB_CMD_ADR_LSB 4
`define RRSB_STAT_BAD_OP 0
`define RRSB_STAT_LAST_LSB 4

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define RRSB_RST_WORK 8'h00
`define RRSB_RST_FLAGS 6'h00
`define RRSB_RST_MEM 8'h00

`endif

// ==== verilog/rrsb_pkg.sv ====
// Types shared by the rotate and subtract ALU modules.
package rrsb_pkg;

    // Instruction codes written to the command register.
    typedef enum logic [2:0] {
        OP_ROT_MEM = 3'h0,
        OP_ROT_WORK = 3'h1,
        OP_ROTC_MEM = 3'h2,
        OP_ROTC_WORK = 3'h3,
        OP_SUB_WORK = 3'h4,
        OP_SUB_MEM = 3'h5
    } rrsb_op_t;

    // Status flags, carry in bit 0.
    typedef struct packed {
        logic chained_nil_flag;
        logic signed_chained_flag;
        logic signed_range_flag;
        logic zero_flag;
        logic low_nibble_borrow_flag;
        logic carry_flag;
    } rrsb_flags_t;

    // Difference with its flags.
    typedef struct packed {
        logic [7:0] data;
        rrsb_flags_t flags;
    } rrsb_sub_t;

    // Register selected by a bus address.
    typedef enum logic [2:0] {
        REG_NONE = 3'h0,
        REG_WORK = 3'h1,
        REG_FLAGS = 3'h2,
        REG_CMD = 3'h3,
        REG_STAT = 3'h4,
        REG_MEM = 3'h5
    } rrsb_reg_t;

endpackage

// ==== verilog/rrsb_rotate.sv ====
// One-position right rotation, plain or through the carry.
`timescale 1ns/1ps

module rrsb_rotate (
    input wire logic [7:0] i_data,
    input wire logic i_carry,
    input wire logic i_via_carry,
    output logic [7:0] o_data,
    output logic o_carry
);

    // Bit 0 leaves at the bottom; bit 7 takes bit 0 or the old carry.
    assign o_data = {(i_via_carry ? i_carry : i_data[0]), i_data[7:1]};
    assign o_carry = i_via_carry ? i_data[0] : i_carry;

endmodule

// ==== verilog/rrsb_subtract.sv ====
// Subtract with borrow: minuend minus subtrahend minus inverted carry, with all six flags.
`timescale 1ns/1ps

module rrsb_subtract (
    input wire logic [7:0] i_minuend,
    input wire logic [7:0] i_subtrahend,
    input wire rrsb_pkg::rrsb_flags_t i_flags,
    output rrsb_pkg::rrsb_sub_t o_result
);
    import rrsb_pkg::*;

    logic borrow_in;
    logic [8:0] full_diff;
    logic [4:0] low_diff;
    logic [7:0] diff;
    logic ovf;
    logic zero;

    // A clear carry means a pending borrow from the lower byte.
    assign borrow_in = ~i_flags.carry_flag;
    assign full_diff = {1'b0, i_minuend} - {1'b0, i_subtrahend} - {8'h00, borrow_in};
    assign low_diff = {1'b0, i_minuend[3:0]} - {1'b0, i_subtrahend[3:0]} - {4'h0, borrow_in};
    assign diff = full_diff[7:0];
    assign ovf = (i_minuend[7] != i_subtrahend[7]) && (diff[7] != i_minuend[7]);
    assign zero = (diff == 8'h00);

    // Carry and nibble flag are 1 when no borrow occurs; chained zero keeps the prior run.
    assign o_result.data = diff;
    assign o_result.flags.carry_flag = ~full_diff[8];
    assign o_result.flags.low_nibble_borrow_flag = ~low_diff[4];
    assign o_result.flags.zero_flag = zero;
    assign o_result.flags.signed_range_flag = ovf;
    assign o_result.flags.signed_chained_flag = ovf ^ diff[7];
    assign o_result.flags.chained_nil_flag = zero & i_flags.chained_nil_flag;

endmodule

// ==== verilog/rrsb_alu.sv ====
// Rotate-right and subtract-with-borrow ALU with data memory, reached over classic Wishbone.
//
// Summary of operation
// RULE_01: Rotate memory byte right, bit 0 to bit 7, write back, flags unchanged.
// RULE_02: Rotate memory byte right into working register; memory and flags unchanged.
// RULE_03: Rotate byte and carry as nine-bit ring; result to memory, only carry changes.
// RULE_04: Ring rotate into working register; carry takes bit 0, memory stays unchanged.
// RULE_05: Working register becomes working minus memory byte minus inverted carry.
// RULE_06: Subtractions write carry 0 on borrow, 1 when result zero or positive.
// RULE_07: Subtractions update all six flags; rotates touch at most the carry.
// RULE_08: Memory byte becomes working minus memory byte minus inverted carry.
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "rrsb_defs.svh"

module rrsb_alu (
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    output logic [7:0] O_WORK,
    output rrsb_pkg::rrsb_flags_t O_FLAGS,
    output logic O_BUSY
);
    import rrsb_pkg::*;

    // ------------------------------------------------------------------------
    // Types and decode helpers.
    // ------------------------------------------------------------------------

    // One-hot sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } rrsb_state_t;

    // Maps a byte address to the register it selects; misaligned means none.
    function automatic rrsb_reg_t rrsb_decode(input logic [7:0] adr);
        rrsb_reg_t sel;
        sel = REG_NONE;
        if (adr[1:0] == 2'h0) begin
            if (adr == `RRSB_OFS_WORK) begin
                sel = REG_WORK;
            end else if (adr == `RRSB_OFS_FLAGS) begin
                sel = REG_FLAGS;
            end else if (adr == `RRSB_OFS_CMD) begin
                sel = REG_CMD;
            end else if (adr == `RRSB_OFS_STAT) begin
                sel = REG_STAT;
            end else if ((adr >= `RRSB_OFS_MEM) &&
                         (adr < 8'(`RRSB_OFS_MEM + 4 * `RRSB_MEM_DEPTH))) begin
                sel = REG_MEM;
            end
        end
        return sel;
    endfunction

    // Widens a byte to a bus word with the upper bits reading zero.
    function automatic logic [31:0] rrsb_word(input logic [7:0] value);
        return {24'h000000, value};
    endfunction

    // ------------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------------
    rrsb_state_t state;
    rrsb_state_t next_state;
    logic [7:0] work;
    rrsb_flags_t flags;
    logic [7:0] mem [`RRSB_MEM_DEPTH];
    rrsb_op_t cmd_op;
    logic [`RRSB_MEM_AW-1:0] cmd_adr;
    logic [`RRSB_CMD_OP_W-1:0] last_op;
    logic bad_op;
    logic ack;
    logic [31:0] rdata;

    // ------------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------------
    rrsb_reg_t reg_sel;
    logic [`RRSB_MEM_AW-1:0] bus_mem_idx;
    logic bus_req;
    logic wr_fire;
    logic wr_work;
    logic wr_flags;
    logic wr_cmd;
    logic wr_stat;
    logic wr_mem;
    logic [31:0] read_mux;
    logic [7:0] status_byte;

    // A new request is taken only while idle, so a running instruction stalls the bus.
    assign reg_sel = rrsb_decode(I_WB_ADR);
    assign bus_mem_idx = I_WB_ADR[`RRSB_MEM_AW+1:2];
    assign bus_req = I_WB_CYC & I_WB_STB & ~ack & (state == ST_IDLE);

    // Writes land on the edge at which the master sees the acknowledge.
    assign wr_fire = ack & I_WB_CYC & I_WB_STB & I_WB_WE & I_WB_SEL[0];
    assign wr_work = wr_fire & (reg_sel == REG_WORK);
    assign wr_flags = wr_fire & (reg_sel == REG_FLAGS);
    assign wr_cmd = wr_fire & (reg_sel == REG_CMD);
    assign wr_stat = wr_fire & (reg_sel == REG_STAT);
    assign wr_mem = wr_fire & (reg_sel == REG_MEM);

    // Status shows the last instruction code and the sticky bad-code bit.
    assign status_byte = {1'b0, last_op, 3'h0, bad_op};

    // Read selection; unmapped addresses answer with zero.
    assign read_mux = (reg_sel == REG_WORK) ? rrsb_word(work) :
                      (reg_sel == REG_FLAGS) ? rrsb_word({2'h0, flags}) :
                      (reg_sel == REG_CMD) ? rrsb_word({cmd_adr, 1'b0, cmd_op}) :
                      (reg_sel == REG_STAT) ? rrsb_word(status_byte) :
                      (reg_sel == REG_MEM) ? rrsb_word(mem[bus_mem_idx]) :
                      32'h00000000;

    // ------------------------------------------------------------------------
    // Datapath units.
    // ------------------------------------------------------------------------
    logic [7:0] src_byte;
    logic via_carry;
    logic [7:0] rot_data;
    logic rot_carry;
    rrsb_sub_t sub_res;

    // The operand byte is the one the command selected.
    assign src_byte = mem[cmd_adr];
    assign via_carry = (cmd_op == OP_ROTC_MEM) || (cmd_op == OP_ROTC_WORK);

    // Plain or through-carry rotation of the operand.
    rrsb_rotate u_rotate (
        .i_data(src_byte),
        .i_carry(flags.carry_flag),
        .i_via_carry(via_carry),
        .o_data(rot_data),
        .o_carry(rot_carry)
    );

    // Working register minus operand minus inverted carry.
    rrsb_subtract u_subtract (
        .i_minuend(work),
        .i_subtrahend(src_byte),
        .i_flags(flags),
        .o_result(sub_res)
    );

    // ------------------------------------------------------------------------
    // Instruction results.
    // ------------------------------------------------------------------------
    logic [7:0] exec_work;
    rrsb_flags_t exec_flags;
    logic exec_mem_we;
    logic [7:0] exec_mem_data;
    logic exec_bad;
    logic exec_go;

    assign exec_go = (state == ST_EXEC);

    // Chooses where each result goes and which flags it changes.
    always_comb begin
        exec_work = work;
        exec_flags = flags;
        exec_mem_we = 1'b0;
        exec_mem_data = src_byte;
        exec_bad = 1'b0;
        unique case (cmd_op)
            OP_ROT_MEM: begin
                exec_mem_we = 1'b1; // [RULE_01]
                exec_mem_data = rot_data; // [RULE_01]
            end
            OP_ROT_WORK: begin
                exec_work = rot_data; // [RULE_02]
            end
            OP_ROTC_MEM: begin
                exec_mem_we = 1'b1; // [RULE_03]
                exec_mem_data = rot_data; // [RULE_03]
                exec_flags.carry_flag = rot_carry; // [RULE_03] [RULE_07]
            end
            OP_ROTC_WORK: begin
                exec_work = rot_data; // [RULE_04]
                exec_flags.carry_flag = rot_carry; // [RULE_04] [RULE_07]
            end
            OP_SUB_WORK: begin
                exec_work = sub_res.data; // [RULE_05]
                exec_flags = sub_res.flags; // [RULE_06] [RULE_07]
            end
            OP_SUB_MEM: begin
                exec_mem_we = 1'b1; // [RULE_08]
                exec_mem_data = sub_res.data; // [RULE_08]
                exec_flags = sub_res.flags; // [RULE_06] [RULE_07]
            end
            default: begin
                exec_bad = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Memory write port.
    // ------------------------------------------------------------------------
    logic mem_we;
    logic [`RRSB_MEM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;

    // The bus and the sequencer never write in the same cycle.
    assign mem_we = wr_mem | (exec_go & exec_mem_we);
    assign mem_wa = exec_go ? cmd_adr : bus_mem_idx;
    assign mem_wd = exec_go ? exec_mem_data : I_WB_DAT[7:0];

    // ------------------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------------------

    // A command write starts one execution cycle, then the sequencer idles.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (wr_cmd) begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------------
    // Bus answer registers.
    // ------------------------------------------------------------------------

    // Acknowledge one cycle after the request, dropped in the following cycle.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req;
        end
    end

    // Read data is captured with the acknowledge and holds until the next request.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            rdata <= 32'h00000000;
        end else if (bus_req) begin
            rdata <= read_mux;
        end
    end

    // ------------------------------------------------------------------------
    // Architectural registers.
    // ------------------------------------------------------------------------

    // Working register: instruction result or software write.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            work <= `RRSB_RST_WORK;
        end else if (exec_go) begin
            work <= exec_work; // [RULE_02] [RULE_04] [RULE_05]
        end else if (wr_work) begin
            work <= I_WB_DAT[7:0];
        end
    end

    // Status flags: instruction result or software write.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            flags <= `RRSB_RST_FLAGS;
        end else if (exec_go) begin
            flags <= exec_flags; // [RULE_07]
        end else if (wr_flags) begin
            flags <= I_WB_DAT[`RRSB_FLAG_W-1:0];
        end
    end

    // Command register latches the code and the operand address.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            cmd_op <= OP_ROT_MEM;
            cmd_adr <= '0;
        end else if (wr_cmd) begin
            cmd_op <= rrsb_op_t'(I_WB_DAT[`RRSB_CMD_OP_LSB +: `RRSB_CMD_OP_W]);
            cmd_adr <= I_WB_DAT[`RRSB_CMD_ADR_LSB +: `RRSB_MEM_AW];
        end
    end

    // Last executed code, and a bad-code bit that is set ahead of a write-one clear.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            last_op <= '0;
            bad_op <= 1'b0;
        end else begin
            if (exec_go) begin
                last_op <= cmd_op;
            end
            if (exec_go & exec_bad) begin
                bad_op <= 1'b1;
            end else if (wr_stat & I_WB_DAT[`RRSB_STAT_BAD_OP]) begin
                bad_op <= 1'b0;
            end
        end
    end

    // Data memory array with a single write port.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            for (int i = 0; i < `RRSB_MEM_DEPTH; i++) begin
                mem[i] <= `RRSB_RST_MEM;
            end
        end else if (mem_we) begin
            mem[mem_wa] <= mem_wd; // [RULE_01] [RULE_03] [RULE_08]
        end
    end

    // ------------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------------
    assign O_WB_ACK = ack;
    assign O_WB_DAT = rdata;
    assign O_WORK = work;
    assign O_FLAGS = flags;
    assign O_BUSY = (state == ST_EXEC);

endmodule

// ==== verif/rrsb_alu_chk.sv ====
// Checker of bus handshake, sequencing and flag behaviour of the rotate and subtract ALU.
`timescale 1ns/1ps
`include "rrsb_defs.svh"

module rrsb_alu_chk (
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    input wire logic [31:0] O_WB_DAT,
    input wire logic O_WB_ACK,
    input wire logic [7:0] O_WORK,
    input wire rrsb_pkg::rrsb_flags_t O_FLAGS,
    input wire logic O_BUSY
);
    import rrsb_pkg::*;
    // --------
    // Helper decodes
    // --------
    logic [2:0] op_q;
    // Bus events and the instruction under execution.
    wire req = I_WB_CYC & I_WB_STB;
    wire wr_ok = req & O_WB_ACK & I_WB_WE & I_WB_SEL[0];
    wire cmd_wr = wr_ok & (I_WB_ADR == `RRSB_OFS_CMD);
    wire work_wr = wr_ok & (I_WB_ADR == `RRSB_OFS_WORK);
    wire work_op = O_BUSY & (op_q == 3'h1 || op_q == 3'h3 || op_q == 3'h4);
    wire [4:0] upper_flags = O_FLAGS[5:1];
    wire chain_nil = O_FLAGS.chained_nil_flag;

    // Remembers the opcode of the last command write.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) op_q <= 3'h0;
        else if (cmd_wr) op_q <= I_WB_DAT[2:0];
    end

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);

    // --------
    // Sequences and assertions
    // --------
    sequence taken_s;
        req && !O_WB_ACK && !O_BUSY;
    endsequence
    sequence exec_s;
        O_BUSY ##1 !O_BUSY;
    endsequence

    ack_answer_a: assert property (taken_s |=> O_WB_ACK) else $error("ack missing");
    ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
    ack_cause_a: assert property (O_WB_ACK |-> $past(req)) else $error("ack without request");
    dat_upper_a: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h0) else $error("upper data");
    busy_start_a: assert property (cmd_wr |=> exec_s) else $error("execution step wrong");
    busy_cause_a: assert property ($rose(O_BUSY) |-> $past(cmd_wr)) else $error("stray busy");
    rot_flags_a: assert property (O_BUSY && op_q < 3'h4 |=> $stable(upper_flags))
        else $error("rotate changed flags");
    rot_mem_a: assert property (O_BUSY && op_q < 3'h2 |=> $stable(O_FLAGS))
        else $error("rotate changed carry");
    sub_zero_a: assert property (O_BUSY && op_q == 3'h4 |=>
        O_FLAGS.zero_flag == (O_WORK == 8'h00) &&
        chain_nil == (O_FLAGS.zero_flag && $past(chain_nil)))
        else $error("zero flags wrong");
    work_cause_a: assert property ($changed(O_WORK) |-> $past(work_op) || $past(work_wr))
        else $error("work changed");
endmodule

bind rrsb_alu rrsb_alu_chk chk_u (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST), .I_WB_CYC(I_WB_CYC),
    .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL),
    .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_WORK(O_WORK),
    .O_FLAGS(O_FLAGS), .O_BUSY(O_BUSY));

// ==== verif/testbench.sv ====
// Self-checking testbench of the rotate and subtract ALU over its Wishbone registers.
`timescale 1ns/1ps
`include "rrsb_defs.svh"

module testbench;
    import rrsb_pkg::*;
    logic clk;
    logic nrst;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic ack;
    logic [7:0] work;
    rrsb_flags_t flags;
    logic busy;
    logic [31:0] rd_q;
    int fails = 0;
    int check_count = 0;

    rrsb_alu dut_u (.I_SYS_CLK(clk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
        .O_WB_ACK(ack), .O_WORK(work), .O_FLAGS(flags), .O_BUSY(busy));

    // --------
    // Bus tasks
    // --------
    // One classic cycle; held until ack is sampled high, released on that edge.
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            $display("MISMATCH at %0t: no acknowledge", $time);
        end
        rd_q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb_cycle(1'b1, a, {24'h0, d}, 4'h1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb_cycle(1'b0, a, 32'h0, 4'hF);
        check(rd_q, exp);
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Clock of 40 ns.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end

    // --------
    // Tests
    // --------
    // Presets operands, runs every opcode and compares against a reference.
    initial begin
        logic [7:0] wv [4];
        logic [7:0] mv [4];
        logic [7:0] w, m, ew, em, ma;
        logic [5:0] fl, ef;
        logic [8:0] d9;
        logic [4:0] n5;
        logic [3:0] idx;
        logic sovf, z, bad;
        wv = '{8'h00, 8'h80, 8'h10, 8'h5A};
        mv = '{8'h01, 8'h01, 8'h01, 8'h5A};
        {cyc, stb, we, adr, sel, wdat} = '0;
        nrst = 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(`RRSB_OFS_WORK, 32'h0);
        rd_chk(`RRSB_OFS_FLAGS, 32'h0);
        rd_chk(`RRSB_OFS_MEM + 8'h3C, 32'h0);
        wr(8'h3C, 8'h55);
        rd_chk(8'h3C, 32'h0);
        rd_chk(8'h41, 32'h0);
        for (int op = 0; op < 8; op++) begin
            for (int k = 0; k < 4; k++) begin
                idx = 4'(k * 5);
                ma = `RRSB_OFS_MEM + {2'b0, idx, 2'b0};
                fl = k[0] ? 6'h3F : 6'h00;
                w = wv[k];
                m = mv[k];
                ew = w;
                em = m;
                ef = fl;
                bad = (op > 5);
                case (op)
                    0: em = {m[0], m[7:1]};
                    1: ew = {m[0], m[7:1]};
                    2: {em, ef[0]} = {fl[0], m[7:1], m[0]};
                    3: {ew, ef[0]} = {fl[0], m[7:1], m[0]};
                    4, 5: begin
                        d9 = {1'b0, w} - {1'b0, m} - {8'h0, ~fl[0]};
                        n5 = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~fl[0]};
                        sovf = (w[7] != m[7]) && (d9[7] != w[7]);
                        z = (d9[7:0] == 8'h00);
                        ef = {z & fl[5], sovf ^ d9[7], sovf, z, ~n5[4], ~d9[8]};
                        if (op == 4) ew = d9[7:0];
                        else em = d9[7:0];
                    end
                    default: ;
                endcase
                wr(`RRSB_OFS_FLAGS, {2'b0, fl});
                wr(`RRSB_OFS_WORK, w);
                wr(ma, m);
                wr(`RRSB_OFS_CMD, {idx, 1'b0, 3'(op)});
                rd_chk(`RRSB_OFS_WORK, {24'h0, ew});
                rd_chk(`RRSB_OFS_FLAGS, {26'h0, ef});
                rd_chk(ma, {24'h0, em});
                check({16'h0, work, 2'b0, flags}, {16'h0, ew, 2'b0, ef});
                wb_cycle(1'b0, `RRSB_OFS_STAT, 32'h0, 4'hF);
                check(rd_q, {25'h0, 3'(op), 3'h0, bad});
                if (bad) wr(`RRSB_OFS_STAT, 8'h01);
            end
        end
        rd_chk(`RRSB_OFS_CMD, 32'hF7);
        // Two rotates back to back; the second is requested only after the busy cycle has ended.
        wr(`RRSB_OFS_MEM + 8'h04, 8'h03);
        wr(`RRSB_OFS_CMD, 8'h10);
        wr(`RRSB_OFS_CMD, 8'h10);
        rd_chk(`RRSB_OFS_MEM + 8'h04, 32'hC0);
        // A write without lane 0 enabled leaves the last preset working value.
        wb_cycle(1'b1, `RRSB_OFS_WORK, 32'hAA, 4'h0);
        rd_chk(`RRSB_OFS_WORK, 32'h5A);
        stop_test();
    end
endmodule
